/* File: scpd_pkg.sv */
// Constants, field layouts and carrier types of the sample-clock phase
// and delay control block.
// Assumes a 32-bit classic Wishbone register bus, 8-bit registers.
package scpd_pkg;

  // ****************************************************************
  // Register indexes (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] IDX_ALIGN_CTRL = 10'h10a;
  localparam logic [9:0] IDX_DELAY_MODE = 10'h110;
  localparam logic [9:0] IDX_SUPER_FINE = 10'h111;
  localparam logic [9:0] IDX_FINE = 10'h112;
  localparam logic [9:0] IDX_STATUS = 10'h113;
  localparam logic [9:0] IDX_LAST_PHASE = 10'h114;
  localparam logic [9:0] IDX_REALIGN_CNT = 10'h115;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int AUTOPHASE_BIT = 7;
  localparam int NEG_WIN_LSB = 2;
  localparam int POS_WIN_LSB = 0;
  localparam int STAT_REALIGN_BIT = 0;
  localparam int STAT_CLAMP_BIT = 1;
  localparam int STAT_IN_WIN_BIT = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_ALIGN_CTRL = 8'h00;
  localparam logic [2:0] RST_DELAY_MODE = 3'h0;
  localparam logic [7:0] RST_SUPER_FINE = 8'h00;
  localparam logic [7:0] RST_FINE = 8'hc0;

  // ****************************************************************
  // Step limits and step sizes
  // ****************************************************************
  localparam logic [7:0] FINE_MAX_SHORT = 8'h10;
  localparam logic [7:0] FINE_MAX_FULL = 8'hc0;
  localparam logic [7:0] SUPER_MAX = 8'h80;
  localparam int FINE_STEP_FS = 1725;
  localparam int SUPER_STEP_FS = 250;
  localparam int DELAY_FS_W = 20;

  // ****************************************************************
  // Delay mode codes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_RSVD = 3'h1,
    MODE_FINE_SHORT = 3'h2,
    MODE_FINE_SHORT_LJ = 3'h3,
    MODE_FINE_FULL = 3'h4,
    MODE_FINE_FULL_ALT = 3'h5,
    MODE_FINE_SUPER = 3'h6,
    MODE_UNLISTED = 3'h7
  } scpd_mode_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scpd_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } scpd_wb_rsp_t;

  typedef struct packed {
    logic fine_en;
    logic super_en;
    logic low_jitter;
    logic clamped;
    logic [7:0] fine_steps;
    logic [7:0] super_steps;
  } scpd_delay_t;

endpackage : scpd_pkg

/* File: scpd_rst_sync.sv */
// Reset release synchroniser.
// Assumes an active-low asynchronous reset from the board.
`timescale 1ns/10ps
`default_nettype none
module scpd_rst_sync
(
  input wire logic i_clk,     // Device clock
  input wire logic i_arst_n,  // Raw reset, active low
  output logic o_rst_n        // Released reset, active low
);
  typedef struct packed {
    logic meta;
    logic held;
  } scpd_rs_state_t;

  scpd_rs_state_t st_r;
  scpd_rs_state_t st_nxt;

  always_comb
  begin
    st_nxt.meta = 1'b1;
    st_nxt.held = st_r.meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_rst_n = st_r.held;
endmodule : scpd_rst_sync
`default_nettype wire

/* File: scpd_delay_map.sv */
// Maps delay mode and step registers onto the applied delay settings.
// Assumes register values already stable on the device clock.
`timescale 1ns/10ps
`default_nettype none
module scpd_delay_map
(
  input wire logic [2:0] i_mode,          // Delay mode select
  input wire logic [7:0] i_fine,          // Fine step register
  input wire logic [7:0] i_super,         // Super-fine step register
  output scpd_pkg::scpd_delay_t o_delay   // Applied settings
);
  import scpd_pkg::*;

  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  always_comb
  begin
    o_delay = '0;
    case (scpd_mode_t'(i_mode))
      MODE_FINE_SHORT, MODE_FINE_SHORT_LJ:
      begin
        o_delay.fine_en = 1'b1;
        o_delay.fine_steps = clamp(i_fine, FINE_MAX_SHORT);
        o_delay.clamped = (i_fine > FINE_MAX_SHORT);
        o_delay.low_jitter = (i_mode == MODE_FINE_SHORT_LJ);
      end
      MODE_FINE_FULL, MODE_FINE_FULL_ALT:
      begin
        o_delay.fine_en = 1'b1;
        o_delay.fine_steps = clamp(i_fine, FINE_MAX_FULL);
        o_delay.clamped = (i_fine > FINE_MAX_FULL);
      end
      MODE_FINE_SUPER:
      begin
        o_delay.fine_en = 1'b1;
        o_delay.super_en = 1'b1;
        o_delay.fine_steps = clamp(i_fine, FINE_MAX_FULL);
        o_delay.super_steps = clamp(i_super, SUPER_MAX);
        o_delay.clamped = (i_fine > FINE_MAX_FULL) ||
                          (i_super > SUPER_MAX);
      end
      default:
      begin
        o_delay = '0;
      end
    endcase
  end
endmodule : scpd_delay_map
`default_nettype wire

/* File: scpd_top.sv */
// Sample-clock divider alignment and delay control with Wishbone
// register access.
// Assumes i_sysref synchronous to i_clk and a classic Wishbone master.
//
// Contract
// - With autophase set, a system reference event outside the window realigns the divider
// - Negative window code 0..3 tolerates 0, 1/2, 1, 3/2 clocks early; the logic tolerates 0, 0, 1, 1 clocks
// - Positive window code 0..3 tolerates 0, 1/2, 1, 3/2 clocks late; the logic tolerates 0, 0, 1, 1 clocks
// - Mode 000 applies no delay, 001 is reserved, 101 acts as 100
// - Modes 010 and 011 give fine delay of 0..16 steps, 011 low jitter
// - Mode 100 gives fine delay over 192 steps without super-fine
// - Mode 110 gives fine over 192 steps plus super-fine over 128
// - Super-fine register is 8-bit, 0.25 ps a step, 0..128, reset 0
// - Fine register is 8-bit, 1.725 ps a step, 0..192, reset 0xc0
`timescale 1ns/10ps
`default_nettype none
module scpd_top
#(
  parameter int DIV_RATIO = 4,   // Device clocks per divided clock
  parameter int PHASE_W = 8      // Half-clock phase counter width
)
(
  input wire logic i_clk,                    // Device clock, 20 MHz
  input wire logic i_arst_n,                 // Async reset, active low
  input wire logic i_wb_cyc,                 // Wishbone cycle
  input wire logic i_wb_stb,                 // Wishbone strobe
  input wire logic i_wb_we,                  // Wishbone write enable
  input wire logic [11:0] i_wb_adr,          // Wishbone byte address
  input wire logic [3:0] i_wb_sel,           // Wishbone byte selects
  input wire logic [31:0] i_wb_dat,          // Wishbone write data
  output logic o_wb_ack,                     // Wishbone acknowledge
  output logic [31:0] o_wb_dat,              // Wishbone read data
  input wire logic i_sysref,                 // System reference level
  output logic o_div_clk,                    // Divided clock
  output logic [PHASE_W-1:0] o_div_phase,    // Divider phase, half clocks
  output logic o_realign,                    // Divider realigned pulse
  output logic o_fine_en,                    // Fine delay active
  output logic o_super_en,                   // Super-fine delay active
  output logic o_low_jitter,                 // Low-jitter fine variant
  output logic [7:0] o_fine_steps,           // Applied fine steps
  output logic [7:0] o_super_steps,          // Applied super-fine steps
  output logic [scpd_pkg::DELAY_FS_W-1:0] o_delay_fs  // Total delay, fs
);
  import scpd_pkg::*;

  // ****************************************************************
  // Constants
  // ****************************************************************
  // Phase counts half device clocks, two per device clock
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(2);
  localparam logic [PHASE_W-1:0] PHASE_WRAP = PHASE_W'(2 * DIV_RATIO);
  localparam logic [PHASE_W-1:0] PHASE_HALF = PHASE_W'(DIV_RATIO);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic autophase;
    logic [1:0] neg_win;
    logic [1:0] pos_win;
    logic [2:0] mode;
    logic [7:0] super_fine;
    logic [7:0] fine;
    logic realign_seen;
    logic clamp_seen;
    logic last_in_win;
    logic [7:0] last_phase;
    logic [7:0] realign_cnt;
    logic sysref_d;
    logic [PHASE_W-1:0] phase;
    logic realign;
    scpd_delay_t dly;
    logic [DELAY_FS_W-1:0] delay_fs;
  } scpd_state_t;

  scpd_state_t st_r;
  scpd_state_t st_nxt;
  scpd_wb_req_t req;
  scpd_delay_t dly_map;
  logic rst_n;
  logic bus_hit;
  logic bus_wr;
  logic [9:0] idx;
  logic sysref_evt;
  logic in_win;
  logic mapped;
  logic [7:0] reg_rd;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Window code in half device clocks
  function automatic logic [PHASE_W-1:0] win_half(input logic [1:0] code);
    win_half = PHASE_W'(code);
  endfunction : win_half

  function automatic logic [DELAY_FS_W-1:0] delay_total(
    input scpd_delay_t d);
    logic [DELAY_FS_W-1:0] f;
    logic [DELAY_FS_W-1:0] s;
    f = DELAY_FS_W'(d.fine_steps) * DELAY_FS_W'(FINE_STEP_FS);
    s = DELAY_FS_W'(d.super_steps) * DELAY_FS_W'(SUPER_STEP_FS);
    delay_total = f + s;
  endfunction : delay_total

  // ****************************************************************
  // Submodules
  // ****************************************************************
  scpd_rst_sync u_rst
  (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .o_rst_n(rst_n)
  );

  scpd_delay_map u_map
  (
    .i_mode(st_r.mode),
    .i_fine(st_r.fine),
    .i_super(st_r.super_fine),
    .o_delay(dly_map)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  always_comb
  begin
    req.cyc = i_wb_cyc;
    req.stb = i_wb_stb;
    req.we = i_wb_we;
    req.adr = i_wb_adr;
    req.sel = i_wb_sel;
    req.dat = i_wb_dat;
  end

  // Pending ack keeps a held strobe from retriggering
  assign bus_hit = req.cyc && req.stb && !st_r.ack;
  assign bus_wr = bus_hit && req.we && req.sel[0];
  assign idx = req.adr[11:2];

  always_comb
  begin
    mapped = 1'b1;
    reg_rd = 8'h00;
    if (idx == IDX_ALIGN_CTRL)
    begin
      reg_rd = {st_r.autophase, 3'h0, st_r.neg_win, st_r.pos_win};
    end
    else if (idx == IDX_DELAY_MODE)
    begin
      reg_rd = {5'h00, st_r.mode};
    end
    else if (idx == IDX_SUPER_FINE)
    begin
      reg_rd = st_r.super_fine;
    end
    else if (idx == IDX_FINE)
    begin
      reg_rd = st_r.fine;
    end
    else if (idx == IDX_STATUS)
    begin
      reg_rd = {5'h00, st_r.last_in_win, st_r.clamp_seen,
                st_r.realign_seen};
    end
    else if (idx == IDX_LAST_PHASE)
    begin
      reg_rd = st_r.last_phase;
    end
    else if (idx == IDX_REALIGN_CNT)
    begin
      reg_rd = st_r.realign_cnt;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // ****************************************************************
  // Alignment window check
  // ****************************************************************
  assign sysref_evt = i_sysref && !st_r.sysref_d;

  // Phase 0 is the expected event point; late events just after it,
  // early ones just before the wrap. Whole-clock steps make odd
  // window codes act like the even code below them.
  always_comb
  begin
    in_win = 1'b0;
    if (st_r.phase == '0)
    begin
      in_win = 1'b1;
    end
    else if (st_r.phase <= win_half(st_r.pos_win))
    begin
      in_win = 1'b1;
    end
    else if ((PHASE_WRAP - st_r.phase) <= win_half(st_r.neg_win))
    begin
      in_win = 1'b1;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = bus_hit;
    st_nxt.rdat = 32'h0000_0000;
    if (bus_hit && !req.we)
    begin
      st_nxt.rdat = {24'h00_0000, reg_rd};
    end
    st_nxt.sysref_d = i_sysref;
    st_nxt.realign = 1'b0;

    // Free-running divider in half-clock units
    if (st_r.phase + PHASE_STEP >= PHASE_WRAP)
    begin
      st_nxt.phase = '0;
    end
    else
    begin
      st_nxt.phase = st_r.phase + PHASE_STEP;
    end

    // Status records every event; only autophase moves the divider
    // Realigned divider takes the event edge as phase 0
    if (sysref_evt)
    begin
      st_nxt.last_phase = 8'(st_r.phase);
      st_nxt.last_in_win = in_win;
      if (st_r.autophase && !in_win)
      begin
        st_nxt.phase = PHASE_STEP;
        st_nxt.realign = 1'b1;
      end
    end

    // Writes with byte lane 0 off are acked but change nothing
    if (bus_wr && mapped)
    begin
      if (idx == IDX_ALIGN_CTRL)
      begin
        st_nxt.autophase = req.dat[AUTOPHASE_BIT];
        st_nxt.neg_win = req.dat[NEG_WIN_LSB +: 2];
        st_nxt.pos_win = req.dat[POS_WIN_LSB +: 2];
      end
      else if (idx == IDX_DELAY_MODE)
      begin
        st_nxt.mode = req.dat[2:0];
      end
      else if (idx == IDX_SUPER_FINE)
      begin
        st_nxt.super_fine = req.dat[7:0];
      end
      else if (idx == IDX_FINE)
      begin
        st_nxt.fine = req.dat[7:0];
      end
      else if (idx == IDX_STATUS)
      begin
        if (req.dat[STAT_REALIGN_BIT])
        begin
          st_nxt.realign_seen = 1'b0;
        end
        if (req.dat[STAT_CLAMP_BIT])
        begin
          st_nxt.clamp_seen = 1'b0;
        end
      end
      else if (idx == IDX_REALIGN_CNT)
      begin
        st_nxt.realign_cnt = 8'h00;
      end
    end

    // Hardware set wins over a clear in the same cycle
    if (st_nxt.realign)
    begin
      st_nxt.realign_seen = 1'b1;
      if (st_r.realign_cnt != 8'hff)
      begin
        st_nxt.realign_cnt = st_r.realign_cnt + 8'h01;
      end
    end
    if (dly_map.clamped)
    begin
      st_nxt.clamp_seen = 1'b1;
    end

    // Applied settings lag the register write by one clock
    st_nxt.dly = dly_map;
    st_nxt.delay_fs = delay_total(dly_map);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Mode and step fields start from reset values; the rest clear
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.mode <= RST_DELAY_MODE;
      st_r.super_fine <= RST_SUPER_FINE;
      st_r.fine <= RST_FINE;
      st_r.autophase <= RST_ALIGN_CTRL[AUTOPHASE_BIT];
      st_r.neg_win <= RST_ALIGN_CTRL[NEG_WIN_LSB +: 2];
      st_r.pos_win <= RST_ALIGN_CTRL[POS_WIN_LSB +: 2];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_wb_ack = st_r.ack;
  assign o_wb_dat = st_r.rdat;
  // Divided clock high over the first half of the period
  assign o_div_clk = (st_r.phase < PHASE_HALF);
  assign o_div_phase = st_r.phase;
  assign o_realign = st_r.realign;
  assign o_fine_en = st_r.dly.fine_en;
  assign o_super_en = st_r.dly.super_en;
  assign o_low_jitter = st_r.dly.low_jitter;
  assign o_fine_steps = st_r.dly.fine_steps;
  assign o_super_steps = st_r.dly.super_steps;
  assign o_delay_fs = st_r.delay_fs;
endmodule : scpd_top
`default_nettype wire

/* File: scpd_top_sva.sv */
// Concurrent checks on the ports of the delay and alignment block.
// Assumes one clock domain and the raw active-low reset.
`timescale 1ns/10ps
`default_nettype none
module scpd_top_sva
#(
  parameter int DIV_RATIO = 4,  // Device clocks per divided clock
  parameter int PHASE_W = 8     // Phase width
)
(
  input wire logic i_clk,                      // Device clock
  input wire logic i_arst_n,                   // Reset, active low
  input wire logic i_wb_cyc,                   // Bus cycle
  input wire logic i_wb_stb,                   // Bus strobe
  input wire logic i_wb_we,                    // Bus write
  input wire logic [11:0] i_wb_adr,            // Bus address
  input wire logic [3:0] i_wb_sel,             // Bus selects
  input wire logic [31:0] i_wb_dat,            // Bus write data
  input wire logic o_wb_ack,                   // Bus ack
  input wire logic [31:0] o_wb_dat,            // Bus read data
  input wire logic i_sysref,                   // System reference
  input wire logic o_div_clk,                  // Divided clock
  input wire logic [PHASE_W-1:0] o_div_phase,  // Divider phase
  input wire logic o_realign,                  // Realign pulse
  input wire logic o_fine_en,                  // Fine active
  input wire logic o_super_en,                 // Super-fine active
  input wire logic o_low_jitter,               // Low-jitter variant
  input wire logic [7:0] o_fine_steps,         // Fine steps
  input wire logic [7:0] o_super_steps,        // Super-fine steps
  input wire logic [scpd_pkg::DELAY_FS_W-1:0] o_delay_fs  // Delay, fs
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence sysref_rise_s;
    !i_sysref ##1 i_sysref;
  endsequence
  sequence mode_none_wr_s;
    i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0] &&
      i_wb_adr[11:2] == scpd_pkg::IDX_DELAY_MODE && i_wb_dat[2:0] == 3'h0;
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held beyond one cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  realign_step_a:
    assert property ((sysref_rise_s ##1 o_realign) |->
      o_div_phase == 'h2 ##1 !o_realign)
    else $error("realign phase or pulse wrong");
  realign_cause_a:
    assert property (o_realign |-> $past(i_sysref) && !$past(i_sysref, 2))
    else $error("realign without reference edge");
  mode_none_a:
    assert property (mode_none_wr_s |-> ##2
      (!o_fine_en && !o_super_en && o_delay_fs == 'h0))
    else $error("delay applied in mode none");
  short_limit_a:
    assert property (o_low_jitter |-> o_fine_en && o_fine_steps <= 8'h10)
    else $error("low jitter fine range wrong");
  step_limit_a:
    assert property (o_fine_steps <= 8'hc0 && o_super_steps <= 8'h80)
    else $error("step count above range");
  super_gate_a:
    assert property (!o_super_en |-> o_super_steps == 8'h0)
    else $error("super-fine steps applied while off");
  delay_sum_a:
    assert property (o_delay_fs == {12'h0, o_fine_steps} * 20'h6bd +
      {12'h0, o_super_steps} * 20'hfa)
    else $error("total delay mismatch");
endmodule : scpd_top_sva
`default_nettype wire

/* File: sysref_clock_phase_delay_ctrl_bench.sv */
// Self-checking bench for the delay and alignment block.
// Assumes scpd_top with default parameters and the checker bound below.
`timescale 1ns/10ps
`default_nettype none
module sysref_clock_phase_delay_ctrl_bench;
  import scpd_pkg::*;
  logic clk, arst_n, cyc, stb, we, sysref;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  logic ack, realign, div_clk, fine_en, super_en, lj;
  logic [7:0] phase, fsteps, ssteps;
  logic [DELAY_FS_W-1:0] dfs;
  int error_cnt = 0;
  int checked = 0;

  scpd_top i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .i_sysref(sysref),
    .o_div_clk(div_clk), .o_div_phase(phase), .o_realign(realign),
    .o_fine_en(fine_en), .o_super_en(super_en), .o_low_jitter(lj),
    .o_fine_steps(fsteps), .o_super_steps(ssteps), .o_delay_fs(dfs));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h0, wd};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_vals;
    xfer(1'b0, IDX_ALIGN_CTRL, 8'h0, r);
    chk(r, 32'h0);
    xfer(1'b0, IDX_DELAY_MODE, 8'h0, r);
    chk(r, 32'h0);
    xfer(1'b0, IDX_SUPER_FINE, 8'h0, r);
    chk(r, 32'h0);
    xfer(1'b0, IDX_FINE, 8'h0, r);
    chk(r, 32'hc0);
    chk({29'h0, fine_en, super_en, lj}, 32'h0);
  endtask : t_reset_vals

  task automatic t_access;
    xfer(1'b1, IDX_ALIGN_CTRL, 8'hff, r);
    xfer(1'b0, IDX_ALIGN_CTRL, 8'h0, r);
    chk(r, 32'h8f);
    xfer(1'b1, IDX_DELAY_MODE, 8'hff, r);
    xfer(1'b0, IDX_DELAY_MODE, 8'h0, r);
    chk(r, 32'h07);
    xfer(1'b0, 10'h200, 8'h0, r);
    chk(r, 32'h0);
  endtask : t_access

  task automatic t_modes;
    logic [7:0] fv [2] = '{8'h20, 8'hc1};
    logic [7:0] sv [2] = '{8'h90, 8'h80};
    int fe, se, ef, es;
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, IDX_FINE, fv[k], r);
      xfer(1'b1, IDX_SUPER_FINE, sv[k], r);
      for (int m = 0; m < 8; m++)
      begin
        xfer(1'b1, IDX_DELAY_MODE, m[7:0], r);
        @(negedge clk);
        fe = (m >= 2 && m <= 6);
        se = (m == 6);
        ef = (m < 4) ? 16 : 192;
        ef = fe ? ((fv[k] < ef) ? fv[k] : ef) : 0;
        es = se ? ((sv[k] < 128) ? sv[k] : 128) : 0;
        chk({31'h0, fine_en}, 32'(fe));
        chk({31'h0, super_en}, 32'(se));
        chk({31'h0, lj}, 32'(m == 3));
        chk({24'h0, fsteps}, 32'(ef));
        chk({24'h0, ssteps}, 32'(es));
        chk({12'h0, dfs}, 32'(ef * 1725 + es * 250));
      end
    end
  endtask : t_modes

  task automatic t_align;
    logic [7:0] ac [9] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h8a,
                           8'h8a, 8'h8a, 8'h85};
    int pv [9] = '{4, 4, 2, 6, 0, 2, 6, 4, 2};
    int ex [9] = '{0, 1, 1, 1, 0, 0, 0, 1, 1};
    int iw [9] = '{0, 0, 0, 0, 1, 1, 1, 0, 0};
    int n;
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b1, IDX_ALIGN_CTRL, ac[i], r);
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (phase !== 8'((pv[i] + 6) % 8) && n < 20);
      @(posedge clk);
      sysref <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk({31'h0, realign}, 32'(ex[i]));
      chk({24'h0, phase}, ex[i] ? 32'h2 : 32'((pv[i] + 2) % 8));
      chk({31'h0, div_clk}, 32'((ex[i] ? 2 : (pv[i] + 2) % 8) < 4));
      @(posedge clk);
      sysref <= 1'b0;
      xfer(1'b0, IDX_LAST_PHASE, 8'h0, r);
      chk(r, 32'(pv[i]));
      xfer(1'b0, IDX_STATUS, 8'h0, r);
      chk({31'h0, r[2]}, 32'(iw[i]));
    end
    xfer(1'b0, IDX_STATUS, 8'h0, r);
    chk(r, 32'h3);
    xfer(1'b1, IDX_STATUS, 8'h3, r);
    xfer(1'b0, IDX_STATUS, 8'h0, r);
    chk(r, 32'h0);
    xfer(1'b0, IDX_REALIGN_CNT, 8'h0, r);
    chk(r, 32'h5);
    xfer(1'b1, IDX_REALIGN_CNT, 8'h0, r);
    xfer(1'b0, IDX_REALIGN_CNT, 8'h0, r);
    chk(r, 32'h0);
  endtask : t_align

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    arst_n = 1'b0;
    {cyc, stb, we, sysref} = 4'h0;
    adr = 12'h0;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset_vals();
    t_access();
    t_modes();
    t_align();
    end_of_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : sysref_clock_phase_delay_ctrl_bench

bind scpd_top scpd_top_sva #(.DIV_RATIO(DIV_RATIO), .PHASE_W(PHASE_W))
  i_sva (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
  .o_wb_dat(o_wb_dat), .i_sysref(i_sysref), .o_div_clk(o_div_clk),
  .o_div_phase(o_div_phase), .o_realign(o_realign),
  .o_fine_en(o_fine_en), .o_super_en(o_super_en),
  .o_low_jitter(o_low_jitter), .o_fine_steps(o_fine_steps),
  .o_super_steps(o_super_steps), .o_delay_fs(o_delay_fs));
`default_nettype wire
